// *** verilog/ivd_pkg.sv ***
// Purpose: constants for the interrupt vector dispatch block
// Assumes: one program word per vector, 11-bit word address
// Notes: source index order matches vector order
// What this block does
// - Every reset cause fetches from address zero
// - External request zero dispatches to 0x0001
// - External request one dispatches to 0x0002
// - Wide timer match A dispatches to 0x0004
// - Wide timer match B dispatches to 0x000c
// - Narrow timer match A dispatches to 0x000d
// - Narrow timer match B dispatches to 0x000e
// - Serial transmit buffer empty dispatches to 0x0008
// - Serial receive complete dispatches to 0x0007
// - Serial transmit complete dispatches to 0x0009
package ivd_pkg;
	localparam int ADDR_W = 11;
	localparam int NUM_SRC = 18;
	localparam int SRC_W = 5;
	localparam logic [10:0] VEC_RESET = 11'h000;
	localparam logic [10:0] VEC_EXT_ZERO = 11'h001;
	localparam logic [10:0] VEC_EXT_ONE = 11'h002;
	localparam logic [10:0] VEC_WT_CAPTURE = 11'h003;
	localparam logic [10:0] VEC_WT_MATCH_A = 11'h004;
	localparam logic [10:0] VEC_WT_OVERFLOW = 11'h005;
	localparam logic [10:0] VEC_NT_OVERFLOW = 11'h006;
	localparam logic [10:0] VEC_RX_COMPLETE = 11'h007;
	localparam logic [10:0] VEC_TX_EMPTY = 11'h008;
	localparam logic [10:0] VEC_TX_COMPLETE = 11'h009;
	localparam logic [10:0] VEC_COMPARATOR = 11'h00a;
	localparam logic [10:0] VEC_PIN_CHANGE = 11'h00b;
	localparam logic [10:0] VEC_WT_MATCH_B = 11'h00c;
	localparam logic [10:0] VEC_NT_MATCH_A = 11'h00d;
	localparam logic [10:0] VEC_NT_MATCH_B = 11'h00e;
	localparam logic [10:0] VEC_SU_START = 11'h00f;
	localparam logic [10:0] VEC_SU_OVERFLOW = 11'h010;
	localparam logic [10:0] VEC_NV_READY = 11'h011;
	localparam logic [10:0] VEC_WATCHDOG = 11'h012;
endpackage

// *** verilog/ivd_vector_rom.sv ***
// Purpose: maps a source index to its vector word address
// Assumes: index 0 is external request zero, up to 17 the watchdog
// Notes: purely combinational table
`timescale 1ns/1ps
module ivd_vector_rom (
	// Lookup
	input wire logic [ivd_pkg::SRC_W-1:0] src_index,
	output logic [ivd_pkg::ADDR_W-1:0] vector_addr
);
	always_comb begin
		case (src_index)
			5'h00: vector_addr = ivd_pkg::VEC_EXT_ZERO;
			5'h01: vector_addr = ivd_pkg::VEC_EXT_ONE;
			5'h02: vector_addr = ivd_pkg::VEC_WT_CAPTURE;
			5'h03: vector_addr = ivd_pkg::VEC_WT_MATCH_A;
			5'h04: vector_addr = ivd_pkg::VEC_WT_OVERFLOW;
			5'h05: vector_addr = ivd_pkg::VEC_NT_OVERFLOW;
			5'h06: vector_addr = ivd_pkg::VEC_RX_COMPLETE;
			5'h07: vector_addr = ivd_pkg::VEC_TX_EMPTY;
			5'h08: vector_addr = ivd_pkg::VEC_TX_COMPLETE;
			5'h09: vector_addr = ivd_pkg::VEC_COMPARATOR;
			5'h0a: vector_addr = ivd_pkg::VEC_PIN_CHANGE;
			5'h0b: vector_addr = ivd_pkg::VEC_WT_MATCH_B;
			5'h0c: vector_addr = ivd_pkg::VEC_NT_MATCH_A;
			5'h0d: vector_addr = ivd_pkg::VEC_NT_MATCH_B;
			5'h0e: vector_addr = ivd_pkg::VEC_SU_START;
			5'h0f: vector_addr = ivd_pkg::VEC_SU_OVERFLOW;
			5'h10: vector_addr = ivd_pkg::VEC_NV_READY;
			5'h11: vector_addr = ivd_pkg::VEC_WATCHDOG;
			default: vector_addr = ivd_pkg::VEC_RESET;
		endcase
	end
endmodule

// *** verilog/ivd_dispatch.sv ***
// Purpose: presents the vector of an accepted event as the next fetch address
// Assumes: core picks the source and pulses accept with its index
// Notes: priority and global enable live in the core
`timescale 1ns/1ps
module ivd_dispatch (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst_b,
	// Reset causes, synchronous pulses or levels
	input wire logic ext_reset_event,
	input wire logic power_on_event,
	input wire logic brown_out_event,
	input wire logic watchdog_reset_event,
	// Acceptance from the core
	input wire logic accept,
	input wire logic [ivd_pkg::SRC_W-1:0] accept_src,
	// Fetch redirect to the core
	output logic redirect_valid,
	output logic [ivd_pkg::ADDR_W-1:0] redirect_addr
);
	logic [ivd_pkg::ADDR_W-1:0] table_addr;
	logic any_reset;
	logic src_ok;
	logic next_redirect_valid;
	logic [ivd_pkg::ADDR_W-1:0] next_redirect_addr;

	function automatic logic legal_src(input logic [ivd_pkg::SRC_W-1:0] s);
		legal_src = (32'(s) < ivd_pkg::NUM_SRC);
	endfunction

	ivd_vector_rom u_rom (
		.src_index(accept_src),
		.vector_addr(table_addr)
	);

	assign any_reset = ext_reset_event | power_on_event | brown_out_event | watchdog_reset_event;
	assign src_ok = legal_src(accept_src);

	// Reset outranks any event accepted in the same cycle
	always_comb begin
		next_redirect_valid = 1'b0;
		next_redirect_addr = redirect_addr;
		if (any_reset) begin
			next_redirect_valid = 1'b1;
			next_redirect_addr = ivd_pkg::VEC_RESET;
		end else if (accept && src_ok) begin
			next_redirect_valid = 1'b1;
			next_redirect_addr = table_addr;
		end
	end

	// Leaving reset also redirects, so the first fetch comes from the reset vector
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			redirect_valid <= 1'b1;
			redirect_addr <= ivd_pkg::VEC_RESET;
		end else begin
			redirect_valid <= next_redirect_valid;
			redirect_addr <= next_redirect_addr;
		end
	end

	property p_reset_vector;
		@(posedge ref_clk) disable iff (!rst_b)
		any_reset |=> (redirect_valid && redirect_addr == ivd_pkg::VEC_RESET);
	endproperty
	a_reset_vector: assert property (p_reset_vector) else $error("reset cause did not fetch zero");

	property p_ext_zero;
		@(posedge ref_clk) disable iff (!rst_b)
		(accept && accept_src == 5'h00 && !any_reset) |=> (redirect_valid && redirect_addr == 11'h001);
	endproperty
	a_ext_zero: assert property (p_ext_zero) else $error("ext request zero vector wrong");

	property p_ext_one;
		@(posedge ref_clk) disable iff (!rst_b)
		(accept && accept_src == 5'h01 && !any_reset) |=> (redirect_valid && redirect_addr == 11'h002);
	endproperty
	a_ext_one: assert property (p_ext_one) else $error("ext request one vector wrong");

	property p_wt_match_a;
		@(posedge ref_clk) disable iff (!rst_b)
		(accept && accept_src == 5'h03 && !any_reset) |=> (redirect_valid && redirect_addr == 11'h004);
	endproperty
	a_wt_match_a: assert property (p_wt_match_a) else $error("wide match a vector wrong");

	property p_wt_match_b;
		@(posedge ref_clk) disable iff (!rst_b)
		(accept && accept_src == 5'h0b && !any_reset) |=> (redirect_valid && redirect_addr == 11'h00c);
	endproperty
	a_wt_match_b: assert property (p_wt_match_b) else $error("wide match b vector wrong");

	property p_nt_match_a;
		@(posedge ref_clk) disable iff (!rst_b)
		(accept && accept_src == 5'h0c && !any_reset) |=> (redirect_valid && redirect_addr == 11'h00d);
	endproperty
	a_nt_match_a: assert property (p_nt_match_a) else $error("narrow match a vector wrong");

	property p_nt_match_b;
		@(posedge ref_clk) disable iff (!rst_b)
		(accept && accept_src == 5'h0d && !any_reset) |=> (redirect_valid && redirect_addr == 11'h00e);
	endproperty
	a_nt_match_b: assert property (p_nt_match_b) else $error("narrow match b vector wrong");

	property p_tx_empty;
		@(posedge ref_clk) disable iff (!rst_b)
		(accept && accept_src == 5'h07 && !any_reset) |=> (redirect_valid && redirect_addr == 11'h008);
	endproperty
	a_tx_empty: assert property (p_tx_empty) else $error("tx empty vector wrong");

	property p_rx_complete;
		@(posedge ref_clk) disable iff (!rst_b)
		(accept && accept_src == 5'h06 && !any_reset) |=> (redirect_valid && redirect_addr == 11'h007);
	endproperty
	a_rx_complete: assert property (p_rx_complete) else $error("rx complete vector wrong");

	property p_tx_complete;
		@(posedge ref_clk) disable iff (!rst_b)
		(accept && accept_src == 5'h08 && !any_reset) |=> (redirect_valid && redirect_addr == 11'h009);
	endproperty
	a_tx_complete: assert property (p_tx_complete) else $error("tx complete vector wrong");

	property p_watchdog;
		@(posedge ref_clk) disable iff (!rst_b)
		(accept && accept_src == 5'h11 && !any_reset) |=> (redirect_valid && redirect_addr == 11'h012);
	endproperty
	a_watchdog: assert property (p_watchdog) else $error("watchdog vector wrong");

	// Remaining table entries, checked against fixed addresses rather than the package
	property p_wt_capture;
		@(posedge ref_clk) disable iff (!rst_b)
		(accept && accept_src == 5'h02 && !any_reset) |=> (redirect_valid && redirect_addr == 11'h003);
	endproperty
	a_wt_capture: assert property (p_wt_capture) else $error("wide capture vector wrong");

	property p_wt_overflow;
		@(posedge ref_clk) disable iff (!rst_b)
		(accept && accept_src == 5'h04 && !any_reset) |=> (redirect_valid && redirect_addr == 11'h005);
	endproperty
	a_wt_overflow: assert property (p_wt_overflow) else $error("wide overflow vector wrong");

	property p_nt_overflow;
		@(posedge ref_clk) disable iff (!rst_b)
		(accept && accept_src == 5'h05 && !any_reset) |=> (redirect_valid && redirect_addr == 11'h006);
	endproperty
	a_nt_overflow: assert property (p_nt_overflow) else $error("narrow overflow vector wrong");

	property p_comparator;
		@(posedge ref_clk) disable iff (!rst_b)
		(accept && accept_src == 5'h09 && !any_reset) |=> (redirect_valid && redirect_addr == 11'h00a);
	endproperty
	a_comparator: assert property (p_comparator) else $error("comparator vector wrong");

	property p_pin_change;
		@(posedge ref_clk) disable iff (!rst_b)
		(accept && accept_src == 5'h0a && !any_reset) |=> (redirect_valid && redirect_addr == 11'h00b);
	endproperty
	a_pin_change: assert property (p_pin_change) else $error("pin change vector wrong");

	property p_su_start;
		@(posedge ref_clk) disable iff (!rst_b)
		(accept && accept_src == 5'h0e && !any_reset) |=> (redirect_valid && redirect_addr == 11'h00f);
	endproperty
	a_su_start: assert property (p_su_start) else $error("serial unit start vector wrong");

	property p_su_overflow;
		@(posedge ref_clk) disable iff (!rst_b)
		(accept && accept_src == 5'h0f && !any_reset) |=> (redirect_valid && redirect_addr == 11'h010);
	endproperty
	a_su_overflow: assert property (p_su_overflow) else $error("serial unit overflow vector wrong");

	property p_nv_ready;
		@(posedge ref_clk) disable iff (!rst_b)
		(accept && accept_src == 5'h10 && !any_reset) |=> (redirect_valid && redirect_addr == 11'h011);
	endproperty
	a_nv_ready: assert property (p_nv_ready) else $error("nonvolatile ready vector wrong");

	// Each reset cause on its own must reach address zero
	property p_pin_reset;
		@(posedge ref_clk) disable iff (!rst_b)
		ext_reset_event |=> (redirect_valid && redirect_addr == 11'h000);
	endproperty
	a_pin_reset: assert property (p_pin_reset) else $error("pin reset vector wrong");

	property p_power_on;
		@(posedge ref_clk) disable iff (!rst_b)
		power_on_event |=> (redirect_valid && redirect_addr == 11'h000);
	endproperty
	a_power_on: assert property (p_power_on) else $error("power-on vector wrong");

	property p_brown_out;
		@(posedge ref_clk) disable iff (!rst_b)
		brown_out_event |=> (redirect_valid && redirect_addr == 11'h000);
	endproperty
	a_brown_out: assert property (p_brown_out) else $error("brown-out vector wrong");

	property p_watchdog_reset;
		@(posedge ref_clk) disable iff (!rst_b)
		watchdog_reset_event |=> (redirect_valid && redirect_addr == 11'h000);
	endproperty
	a_watchdog_reset: assert property (p_watchdog_reset) else $error("watchdog reset vector wrong");

	property p_reset_beats_accept;
		@(posedge ref_clk) disable iff (!rst_b)
		(any_reset && accept) |=> (redirect_valid && redirect_addr == 11'h000);
	endproperty
	a_reset_beats_accept: assert property (p_reset_beats_accept) else $error("accept beat a reset cause");

	// A bad index must not redirect, or the core would jump into the table default
	property p_refused;
		@(posedge ref_clk) disable iff (!rst_b)
		(accept && accept_src >= 5'h12 && !any_reset) |=> !redirect_valid;
	endproperty
	a_refused: assert property (p_refused) else $error("refused index redirected");

	// Limitation: only the vector table is reachable, never code past it
	property p_table_range;
		@(posedge ref_clk) disable iff (!rst_b)
		redirect_valid |-> (redirect_addr <= 11'h012);
	endproperty
	a_table_range: assert property (p_table_range) else $error("redirect outside vector table");

	property p_idle_quiet;
		@(posedge ref_clk) disable iff (!rst_b)
		(!any_reset && !(accept && src_ok)) |=> (!redirect_valid && $stable(redirect_addr));
	endproperty
	a_idle_quiet: assert property (p_idle_quiet) else $error("redirect without cause");
endmodule

// *** test/ivd_core_model.sv ***
// Purpose: processor core stand-in that follows fetch redirects
// Assumes: one program word per fetch, redirect taken at the next edge
// Notes: runs straight-line code otherwise, so a missed redirect shows as pc + 1
`timescale 1ns/1ps
module ivd_core_model (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst_b,
	// Redirect from the dispatch block
	input wire logic redirect_valid,
	input wire logic [10:0] redirect_addr,
	// Address the core fetches next
	output logic [10:0] next_fetch
);
	logic [10:0] pc;
	always_comb begin
		next_fetch = redirect_valid ? redirect_addr : pc + 11'h001;
	end
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) pc <= 11'h000;
		else pc <= next_fetch;
	end
endmodule

// *** test/tb_top.sv ***
// Purpose: self-checking bench for the vector dispatch block
// Assumes: inputs driven on the falling edge, outputs read 1 ns after the rising edge
// Notes: reset causes checked alone and against a same-cycle accept
`timescale 1ns/1ps
module tb_top;
	logic ref_clk = 0, rst_b = 0, ext_reset_event = 0, power_on_event = 0, brown_out_event = 0;
	logic watchdog_reset_event = 0, accept = 0;
	logic [4:0] accept_src = 5'h00;
	logic redirect_valid;
	logic [10:0] redirect_addr, next_fetch;
	int error_cnt = 0, samples_checked = 0, exp_valid = 1, exp_addr = 0, r;
	logic [31:0] seed = 32'd73659;
	int vec[18] = '{1, 2, 3, 4, 5, 6, 7, 8, 9, 'h0a, 'h0b, 'h0c, 'h0d, 'h0e, 'h0f, 'h10, 'h11, 'h12};
	ivd_dispatch i_ivd_dispatch (.ref_clk(ref_clk), .rst_b(rst_b), .ext_reset_event(ext_reset_event),
		.power_on_event(power_on_event), .brown_out_event(brown_out_event),
		.watchdog_reset_event(watchdog_reset_event), .accept(accept), .accept_src(accept_src),
		.redirect_valid(redirect_valid), .redirect_addr(redirect_addr));
	ivd_core_model i_ivd_core_model (.ref_clk(ref_clk), .rst_b(rst_b), .redirect_valid(redirect_valid),
		.redirect_addr(redirect_addr), .next_fetch(next_fetch));
	initial begin
		forever #5 ref_clk = ~ref_clk;
	end
	function automatic logic [31:0] xs(input logic [31:0] x);
		x = x ^ (x << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction
	task automatic cmp(input logic [10:0] got, input int exp);
		samples_checked++;
		if (got !== exp[10:0]) begin
			error_cnt++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp[10:0]);
		end
	endtask
	task automatic check_all();
		cmp({10'h000, redirect_valid}, exp_valid);
		cmp(redirect_addr, exp_addr);
		if (exp_valid == 1) cmp(next_fetch, exp_addr);
	endtask
	// One request cycle: drive on the falling edge, compare after the next rising edge
	task automatic step(input logic [3:0] causes, input logic acc, input int src);
		@(negedge ref_clk);
		{ext_reset_event, power_on_event, brown_out_event, watchdog_reset_event} = causes;
		accept = acc;
		accept_src = src[4:0];
		exp_valid = 0;
		if (causes != 4'h0) begin
			exp_valid = 1;
			exp_addr = 0;
		end else if (acc && src < 18) begin
			exp_valid = 1;
			exp_addr = vec[src];
		end
		@(posedge ref_clk);
		#1;
		check_all();
	endtask
	task automatic stop_test();
		$display("checks %0d mismatches %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	initial begin
		#100000;
		error_cnt++;
		stop_test();
	end
	initial begin
		repeat (3) @(posedge ref_clk);
		#1;
		check_all();
		@(negedge ref_clk);
		rst_b = 1;
		@(posedge ref_clk);
		#1;
		exp_valid = 0;
		check_all();
		for (int c = 0; c < 4; c++) step(4'h1 << c, 1'b0, 0);
		for (int c = 0; c < 4; c++) step(4'h1 << c, 1'b1, c + 4);
		step(4'h0, 1'b1, 0);
		step(4'h0, 1'b1, 1);
		step(4'h0, 1'b1, 3);
		step(4'h0, 1'b1, 11);
		step(4'h0, 1'b1, 12);
		step(4'h0, 1'b1, 13);
		step(4'h0, 1'b1, 7);
		step(4'h0, 1'b1, 6);
		step(4'h0, 1'b1, 8);
		for (int s = 0; s < 18; s++) step(4'h0, 1'b1, s);
		step(4'h0, 1'b0, 0);
		$display("fixed vector test done");
		// Random back-to-back traffic, refused indexes included
		for (int i = 0; i < 400; i++) begin
			seed = xs(seed);
			r = int'(seed[15:0]);
			step((seed[18:16] == 3'h0) ? (4'h1 << seed[20:19]) : 4'h0, seed[21], r % 24);
		end
		$display("random test done");
		@(negedge ref_clk);
		rst_b = 0;
		{ext_reset_event, power_on_event, brown_out_event, watchdog_reset_event} = 4'h0;
		accept = 1'b0;
		exp_valid = 1;
		exp_addr = 0;
		#1;
		check_all();
		@(negedge ref_clk);
		rst_b = 1;
		@(posedge ref_clk);
		#1;
		exp_valid = 0;
		check_all();
		step(4'h0, 1'b1, 17);
		$display("mid-run reset test done");
		stop_test();
	end
endmodule
